// *** core/rsu_pkg.sv ***
/*
  Shared constants and carrier types for the remote upgrade shift interface.
  Assumes a single upgrade clock domain and user fabric logic on that clock.
*/
package rsu_pkg;

  // ----------------------------------------------------------------
  // Register widths and field positions
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 41;
  localparam int INREG_W = 39;
  localparam int PRESENT_W = 34;
  localparam int PRIOR_W = 32;
  localparam int WD_W = 29;
  localparam int MSM_W = 4;
  localparam int SEL_HI = 40;
  localparam int SEL_LO = 39;
  localparam int IMG_SEL_BIT = 13;
  localparam int IMG_OVR_BIT = 12;
  localparam int PRIOR_FLAG_LO = 28;
  localparam int PRIOR_MSM_LO = 22;

  // ----------------------------------------------------------------
  // Capture word selectors held in shift register bits 40:39
  // ----------------------------------------------------------------
  localparam logic [1:0] CAP_PRESENT = 2'h0;
  localparam logic [1:0] CAP_PRIOR1 = 2'h1;
  localparam logic [1:0] CAP_PRIOR2 = 2'h2;
  localparam logic [1:0] CAP_INREG = 2'h3;

  // ----------------------------------------------------------------
  // Master state machine codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MSM_IMG0 = 4'h2;
  localparam logic [3:0] MSM_IMG1_REVERT = 4'h3;
  localparam logic [3:0] MSM_IMG1 = 4'h4;
  localparam logic [3:0] MSM_IMG0_REVERT = 4'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [40:0] SHIFT_RST = 41'h0;
  localparam logic [38:0] INREG_RST = 39'h0;
  localparam logic [31:0] PRIOR_RST = 32'h0;
  localparam logic [28:0] WD_CNT_RST = 29'h0;
  // Pin sync order {image_pin, status_n, crc_error, ext_reconfig_n}, idle levels.
  localparam logic [3:0] PIN_SYNC_RST = 4'h5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int KICK_LOW_NS = 250;
  localparam int KICK_LOW_CYC = (KICK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic shift_sel;
    logic capture_sel;
    logic serial_in;
  } rsu_ctrl_t;

  typedef struct packed {
    logic ext_pin;
    logic crc_err;
    logic status_pin;
    logic wd_expire;
    logic user_req;
  } rsu_src_t;

endpackage

// *** core/rsu_shift_iface.sv ***
/*
  Remote upgrade shift interface: shift register, input register, status words,
  a compact master state machine model, watchdog restart and source priority.
  Assumes user fabric logic drives the mode, serial and request inputs on
  clk_sys_i; the device pins (image select, reconfigure, status, checksum) are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps

// Overview of operation
// - Update copies shift bits 38:0 into input register.
// - Shift loads serial bit, old bits 38:1.
// - Capture loads word chosen by bits 40:39.
// - Shift mode presents captured word serially.
// - Input bit 13 picks image under override.
// - Input bit 12 lets register override pin.
// - Present status bits 33:30 hold machine state.
// - Present status bit 29 shows watchdog enable.
// - Present status bits 28:0 hold watchdog limit.
// - Prior status bits 31:28 flag reconfiguration source.
// - Simultaneous sources record only highest flag.
// - Prior bits 25:22 hold state; rest zero.
// - Machine tracks mode; parameter WD_ENABLE enables watchdog.
// - Codes 2,4 normal; 3,5 after revert.
// - Serial output updates every edge while shifting.
// - Falling edge of kick restarts the watchdog.
// - Falling edge of request reconfigures when upgrade is enabled.
module rsu_shift_iface #(
  parameter logic [28:0] WD_LIMIT = 29'h1fffffff,
  parameter logic WD_ENABLE = 1'b1,
  parameter logic UPGRADE_ENABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // User logic control
  input wire logic shift_or_load_select_i,
  input wire logic capture_or_update_select_i,
  input wire logic upgrade_serial_in_i,
  input wire logic watchdog_kick_n_i,
  input wire logic logic_reconfig_request_n_i,
  // Device pins
  input wire logic image_select_pin_i,
  input wire logic ext_reconfig_n_i,
  input wire logic status_pin_n_i,
  input wire logic checksum_error_i,
  // Results
  output logic upgrade_serial_out_o,
  output logic reconfig_pulse_o,
  output logic image_choice_o,
  output logic [3:0] msm_state_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Keeps only the highest-ranked flag; a lone user request leaves no flag.
  function automatic logic [3:0] top_flag(input rsu_pkg::rsu_src_t s);
    logic [3:0] f;
    f = 4'h0;
    if (s.ext_pin) begin
      f = 4'h8;
    end else if (s.crc_err) begin
      f = 4'h4;
    end else if (s.status_pin) begin
      f = 4'h2;
    end else if (s.wd_expire) begin
      f = 4'h1;
    end
    return f;
  endfunction

  function automatic logic img_of(input logic [3:0] code);
    return (code == rsu_pkg::MSM_IMG1) || (code == rsu_pkg::MSM_IMG1_REVERT);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;

  assign pin_raw = {image_select_pin_i, status_pin_n_i, checksum_error_i, ext_reconfig_n_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_sync
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pin_meta[g] <= rsu_pkg::PIN_SYNC_RST[g];
          pin_sync[g] <= rsu_pkg::PIN_SYNC_RST[g];
          pin_last[g] <= rsu_pkg::PIN_SYNC_RST[g];
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
          pin_last[g] <= pin_sync[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shift and input registers
  // ----------------------------------------------------------------
  rsu_pkg::rsu_ctrl_t ctrl;
  logic [40:0] shreg;
  logic [40:0] next_shreg;
  logic [38:0] inreg;
  logic [38:0] next_inreg;
  logic [33:0] present_word;
  logic [31:0] prior1;
  logic [31:0] prior2;
  logic [3:0] msm;
  logic [28:0] wd_cnt;
  logic wd_run;

  assign ctrl = '{shift_sel: shift_or_load_select_i,
                  capture_sel: capture_or_update_select_i,
                  serial_in: upgrade_serial_in_i};
  assign wd_run = WD_ENABLE;
  assign present_word = {msm, wd_run, WD_LIMIT};

  always_comb begin
    next_shreg = shreg;
    next_inreg = inreg;
    if (ctrl.shift_sel) begin
      // Bits 40:39 follow the last two serial bits so a selector can be loaded.
      next_shreg[38:0] = {ctrl.serial_in, shreg[38:1]};
      next_shreg[40:39] = {ctrl.serial_in, shreg[40]};
    end else if (ctrl.capture_sel) begin
      case (shreg[rsu_pkg::SEL_HI:rsu_pkg::SEL_LO])
        rsu_pkg::CAP_PRESENT: next_shreg[38:0] = {5'h0, present_word};
        rsu_pkg::CAP_PRIOR1: next_shreg[38:0] = {7'h0, prior1};
        rsu_pkg::CAP_PRIOR2: next_shreg[38:0] = {7'h0, prior2};
        default: next_shreg[38:0] = inreg;
      endcase
    end else begin
      next_inreg = shreg[38:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shreg <= rsu_pkg::SHIFT_RST;
      inreg <= rsu_pkg::INREG_RST;
    end else begin
      shreg <= next_shreg;
      inreg <= next_inreg;
    end
  end

  // Bit 0 is a flop, so the serial output changes on every shifting edge.
  assign upgrade_serial_out_o = shreg[0];

  // ----------------------------------------------------------------
  // Watchdog and reconfiguration sources
  // ----------------------------------------------------------------
  logic kick_last;
  logic req_last;
  logic kick_fall;
  logic [28:0] next_wd_cnt;
  rsu_pkg::rsu_src_t src;
  logic event_hit;

  assign kick_fall = kick_last && !watchdog_kick_n_i;
  assign src.ext_pin = pin_last[0] && !pin_sync[0];
  assign src.crc_err = !pin_last[1] && pin_sync[1];
  assign src.status_pin = pin_last[2] && !pin_sync[2];
  assign src.wd_expire = wd_run && (wd_cnt == WD_LIMIT);
  // A request is honoured only with the upgrade feature switched on.
  assign src.user_req = UPGRADE_ENABLE && req_last && !logic_reconfig_request_n_i;
  assign event_hit = |src;

  always_comb begin
    next_wd_cnt = wd_cnt;
    if (!wd_run || kick_fall || event_hit) begin
      next_wd_cnt = rsu_pkg::WD_CNT_RST;
    end else if (wd_cnt != WD_LIMIT) begin
      next_wd_cnt = wd_cnt + 29'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_cnt <= rsu_pkg::WD_CNT_RST;
      kick_last <= 1'b1;
      req_last <= 1'b1;
    end else begin
      wd_cnt <= next_wd_cnt;
      kick_last <= watchdog_kick_n_i;
      req_last <= logic_reconfig_request_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Master state machine and prior state words
  // ----------------------------------------------------------------
  logic [3:0] flags;
  logic [3:0] next_msm;
  logic [31:0] next_prior1;
  logic [31:0] next_prior2;
  logic want_img;
  logic next_reconfig;
  logic next_choice;

  assign flags = top_flag(src);
  // Register choice replaces the pin only with override set.
  assign want_img = inreg[rsu_pkg::IMG_OVR_BIT] ? inreg[rsu_pkg::IMG_SEL_BIT] :
                    pin_sync[3];

  always_comb begin
    next_msm = msm;
    next_prior1 = prior1;
    next_prior2 = prior2;
    next_reconfig = 1'b0;
    if (event_hit) begin
      next_reconfig = 1'b1;
      next_prior2 = prior1;
      next_prior1 = {flags, 2'h0, msm, 22'h0};
      if (flags[2] || flags[0]) begin
        // A checksum error or watchdog expiry reverts to the other image rather than reloading the failed one.
        next_msm = img_of(msm) ? rsu_pkg::MSM_IMG0_REVERT : rsu_pkg::MSM_IMG1_REVERT;
      end else begin
        next_msm = want_img ? rsu_pkg::MSM_IMG1 : rsu_pkg::MSM_IMG0;
      end
    end
    next_choice = img_of(next_msm);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      msm <= rsu_pkg::MSM_IMG0;
      prior1 <= rsu_pkg::PRIOR_RST;
      prior2 <= rsu_pkg::PRIOR_RST;
      reconfig_pulse_o <= 1'b0;
      image_choice_o <= 1'b0;
    end else begin
      msm <= next_msm;
      prior1 <= next_prior1;
      prior2 <= next_prior2;
      reconfig_pulse_o <= next_reconfig;
      image_choice_o <= next_choice;
    end
  end

  assign msm_state_o = msm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence upd_seq;
    !shift_or_load_select_i && !capture_or_update_select_i;
  endsequence

  sequence user_req_seq;
    logic_reconfig_request_n_i ##1 !logic_reconfig_request_n_i;
  endsequence

  update_copy_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    upd_seq |=> inreg == $past(shreg[38:0]))
    else $error("Update did not copy the shift register.");

  shift_move_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    shift_or_load_select_i |=> (shreg[38:0] == {$past(upgrade_serial_in_i), $past(shreg[38:1])})
      && $stable(inreg))
    else $error("Shift step moved the wrong bits.");

  capture_word_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !shift_or_load_select_i && capture_or_update_select_i && shreg[40:39] == 2'h1
      |=> shreg[38:0] == {7'h0, $past(prior1)})
    else $error("Capture loaded the wrong prior word.");

  serial_lsb_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    shift_or_load_select_i [*2] |-> upgrade_serial_out_o == $past(shreg[1]))
    else $error("Serial output is not the next low bit.");

  present_fields_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    nrst_i && !shift_or_load_select_i && capture_or_update_select_i && shreg[40:39] == 2'h0
      |=> shreg[33:30] == $past(msm) && shreg[29] == WD_ENABLE && shreg[28:0] == WD_LIMIT)
    else $error("Present status word fields are wrong.");

  source_rank_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    src.ext_pin |=> prior1[31:28] == 4'h8 && prior1[25:22] == $past(msm)
      && prior1[27:26] == 2'h0 && prior1[21:0] == 22'h0)
    else $error("Prior status word ranks sources wrongly.");

  image_pick_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    src.user_req && !src.ext_pin && !src.crc_err && !src.status_pin && !src.wd_expire
      && inreg[12] |=> image_choice_o == $past(inreg[13]))
    else $error("Override did not pick the register image.");

  kick_restart_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    kick_last && !watchdog_kick_n_i |=> wd_cnt == 29'h0)
    else $error("Kick edge did not restart the watchdog.");

  user_reconfig_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    user_req_seq |=> reconfig_pulse_o == UPGRADE_ENABLE)
    else $error("User request did not start reconfiguration.");

  revert_code_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    src.crc_err && !src.ext_pin && !img_of(msm) |=> msm == 4'h3)
    else $error("Checksum error did not revert to image one.");

endmodule

// *** verification/rsu_user_model.sv ***
/*
  User fabric model that drives the upgrade control, kick and request inputs.
  Assumes one clock; after the blocking defaults at time zero, every drive lands by non-blocking assignment at a rising edge.
*/
`timescale 1ns/1ps
module rsu_user_model (
  // Clock and serial return
  input wire logic clk_sys_i,
  input wire logic serial_out_i,
  // Control drives
  output rsu_pkg::rsu_ctrl_t ctrl_o,
  output logic kick_n_o,
  output logic req_n_o
);
  logic kick_en = 1'b1;
  int kick_cnt = 0;
  initial begin
    ctrl_o = 3'h2;
    kick_n_o = 1'b1;
    req_n_o = 1'b1;
  end
  // ----------------------------------------------------------------
  // Watchdog kick
  // ----------------------------------------------------------------
  // Low for the minimum width every 100 cycles, well inside the limit.
  // A started pulse always runs its full width, so a late disable never leaves a short kick.
  always @(posedge clk_sys_i) begin
    kick_cnt <= (kick_cnt == 99) ? 0 : kick_cnt + 1;
    kick_n_o <= !(kick_cnt < rsu_pkg::KICK_LOW_CYC
                  && (!kick_n_o || (kick_en && kick_cnt == 0)));
  end
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic step(input logic s, input logic c, input logic d);
    ctrl_o <= '{shift_sel: s, capture_sel: c, serial_in: d};
    @(posedge clk_sys_i);
  endtask
  // Ends in capture mode, since an idle update would overwrite the input word.
  task automatic write_word(input logic [38:0] w);
    w = w & 39'h3000;
    for (int i = 0; i < 39; i++) step(1'b1, 1'b0, w[i]);
    step(1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0);
  endtask
  // Serial output is sampled at the falling edge, where bit 0 has settled.
  task automatic read_word(input logic [1:0] sel, output logic [38:0] w);
    step(1'b1, 1'b0, sel[0]);
    step(1'b1, 1'b0, sel[1]);
    step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 39; i++) begin
      ctrl_o <= '{shift_sel: 1'b1, capture_sel: 1'b0, serial_in: i[0]};
      @(negedge clk_sys_i);
      w[i] = serial_out_i;
      @(posedge clk_sys_i);
    end
    step(1'b0, 1'b1, 1'b0);
  endtask
  task automatic request();
    req_n_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    req_n_o <= 1'b1;
  endtask
endmodule

// *** verification/tb_top.sv ***
/*
  Self-checking bench for the remote upgrade shift interface.
  Assumes the user model drives controls and the bench drives the device pins.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [28:0] LIMIT = 29'h100;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  rsu_pkg::rsu_ctrl_t ctrl;
  logic kick_n, req_n, sout, pulse, img_choice;
  logic img_pin = 1'b0, ext_n = 1'b1, stat_n = 1'b1, crc = 1'b0;
  logic [3:0] msm;
  logic [3:0] exp_msm = rsu_pkg::MSM_IMG0;
  logic [38:0] inreg = 39'h0, got;
  logic [31:0] prior_q[$] = '{32'h0, 32'h0};
  int errors = 0, total_checks = 0, cycles = 0, pulses = 0;
  integer seed = 32'hca45;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  rsu_shift_iface #(.WD_LIMIT(LIMIT)) rsu_shift_iface_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .shift_or_load_select_i(ctrl.shift_sel), .capture_or_update_select_i(ctrl.capture_sel),
    .upgrade_serial_in_i(ctrl.serial_in), .watchdog_kick_n_i(kick_n),
    .logic_reconfig_request_n_i(req_n), .image_select_pin_i(img_pin),
    .ext_reconfig_n_i(ext_n), .status_pin_n_i(stat_n), .checksum_error_i(crc),
    .upgrade_serial_out_o(sout), .reconfig_pulse_o(pulse),
    .image_choice_o(img_choice), .msm_state_o(msm));
  rsu_user_model rsu_user_model_i (.clk_sys_i(clk_sys_i), .serial_out_i(sout),
    .ctrl_o(ctrl), .kick_n_o(kick_n), .req_n_o(req_n));
  always #20 clk_sys_i = ~clk_sys_i;
  // A hang counts as a mismatch.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (pulse === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [38:0] exp, input logic [38:0] act);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  task automatic read_chk(input logic [1:0] sel, input logic [38:0] exp);
    rsu_user_model_i.read_word(sel, got);
    check(exp, got);
  endtask
  // Source order {ext, crc, status, watchdog, user request}.
  task automatic fire(input logic [4:0] src);
    logic [3:0] flags;
    logic one;
    int n;
    flags = src[4] ? 4'h8 : src[3] ? 4'h4 : src[2] ? 4'h2 : {3'h0, src[1]};
    one = (exp_msm == rsu_pkg::MSM_IMG1) || (exp_msm == rsu_pkg::MSM_IMG1_REVERT);
    prior_q.push_front({flags, 2'h0, exp_msm, 22'h0});
    if (flags[2] | flags[0]) exp_msm = one ? rsu_pkg::MSM_IMG0_REVERT : rsu_pkg::MSM_IMG1_REVERT;
    else exp_msm = (inreg[12] ? inreg[13] : img_pin) ? rsu_pkg::MSM_IMG1 : rsu_pkg::MSM_IMG0;
    n = pulses;
    ext_n <= ~src[4];
    crc <= src[3];
    stat_n <= ~src[2];
    rsu_user_model_i.kick_en <= ~src[1];
    if (src[0]) rsu_user_model_i.request();
    for (int k = 0; k < 500 && pulses == n; k++) @(posedge clk_sys_i);
    rsu_user_model_i.kick_en <= 1'b1;
    ext_n <= 1'b1;
    crc <= 1'b0;
    stat_n <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check(n + 1, pulses);
    check(exp_msm, msm);
    check(exp_msm == rsu_pkg::MSM_IMG1 || exp_msm == rsu_pkg::MSM_IMG1_REVERT,
          img_choice);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    check(rsu_pkg::MSM_IMG0, msm);
    check(1'b0, sout);
    check(1'b0, img_choice);
    read_chk(rsu_pkg::CAP_PRESENT, {5'h0, exp_msm, 1'b1, LIMIT});
    // Every override and select pairing, against a random pin level.
    for (int i = 0; i < 4; i++) begin
      inreg = {25'h0, i[1:0], 12'h0};
      img_pin <= 1'($random(seed));
      rsu_user_model_i.write_word(inreg | ({7'h0, $random(seed)} & 39'h7fffffcfff));
      read_chk(rsu_pkg::CAP_INREG, inreg);
      fire(5'h10);
    end
    fire(5'h18);
    read_chk(rsu_pkg::CAP_PRIOR1, {7'h0, prior_q[0]});
    fire(5'h04);
    fire(5'h08);
    read_chk(rsu_pkg::CAP_PRIOR1, {7'h0, prior_q[0]});
    read_chk(rsu_pkg::CAP_PRIOR2, {7'h0, prior_q[1]});
    fire(5'h01);
    // Steady kicking must hold off expiry well past the limit.
    repeat (600) @(posedge clk_sys_i);
    check(exp_msm, msm);
    fire(5'h02);
    read_chk(rsu_pkg::CAP_PRIOR1, {7'h0, prior_q[0]});
    read_chk(rsu_pkg::CAP_PRESENT, {5'h0, exp_msm, 1'b1, LIMIT});
    read_chk(rsu_pkg::CAP_INREG, inreg);
    // A checksum error while image zero runs must revert to image one.
    fire(5'h08);
    read_chk(rsu_pkg::CAP_PRIOR2, {7'h0, prior_q[1]});
    complete_run();
  end
endmodule
